// ==== hdl/dialer_pkg.sv ====
/*
  package of the telephone dialer: register indices, field positions, reset values,
  state codes, timing figures and derived cycle counts, and tone step constants.
  assumes a 40 MHz system clock and a 32-bit APB register bus with byte addresses.
*/
package dialer_pkg;

  // -------------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -------------------------------------------------------------------------
  localparam logic [15:0] IDX_CALL_CTRL   = 16'hFF14; // hold, pause, flash triggers
  localparam logic [15:0] IDX_INTERDIGIT  = 16'hFF15; // interdigit_pause_select
  localparam logic [15:0] IDX_TONE_CTRL   = 16'hFF16; // continuous, duration, row, column
  localparam logic [15:0] IDX_DIAL_CODE   = 16'hFF17; // dial_code
  localparam logic [15:0] IDX_LINE_CTRL   = 16'hFF18; // hook, receive mute, transmit mute
  localparam logic [15:0] IDX_MODE        = 16'hFF19; // tone_mode select
  localparam logic [15:0] IDX_FLASH_TIME  = 16'hFF1A; // flash_time_select
  localparam logic [15:0] IDX_PAUSE_TIME  = 16'hFF1B; // pause_time_select
  localparam logic [15:0] IDX_IRQ_MASK    = 16'hFFE9; // dialing_interrupt_mask
  localparam logic [15:0] IDX_IRQ_FLAG    = 16'hFFF9; // dialing_interrupt_flag

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int BIT_FLASH    = 0;
  localparam int BIT_PAUSE    = 1;
  localparam int BIT_HOLD     = 2;
  localparam int BIT_COLUMN   = 0;
  localparam int BIT_ROW      = 1;
  localparam int BIT_DURATION = 2;
  localparam int BIT_CONTIN   = 3;
  localparam int BIT_TX_MUTE  = 0;
  localparam int BIT_RX_MUTE  = 1;
  localparam int BIT_HOOK     = 2;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [3:0] RST_DIAL_CODE  = 4'h0;
  localparam logic [3:0] RST_INTERDIGIT = 4'h8; // 750 ms
  localparam logic [3:0] RST_FLASH_TIME = 4'h1;
  localparam logic [3:0] RST_PAUSE_TIME = 4'h1;
  localparam logic [7:0] TONE_MID_LEVEL = 8'h80; // half-supply dc level

  // -------------------------------------------------------------------------
  // states
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_BREAK      = 3'b001,
    ST_MAKE       = 3'b010,
    ST_INTERDIGIT = 3'b011,
    ST_TONE       = 3'b100,
    ST_FLASH      = 3'b101,
    ST_PAUSE      = 3'b110
  } dial_state_t;

  // -------------------------------------------------------------------------
  // timing: figures in microseconds, counts in 25 ns cycles
  // -------------------------------------------------------------------------
  localparam longint CLK_PER_US        = 40;
  localparam longint BREAK_US          = 60000;
  localparam longint MAKE_US           = 40000;
  localparam longint INTERDIGIT_UNIT_US = 93750;
  localparam longint TONE_LONG_US      = 94000;
  localparam longint TONE_SHORT_US     = 47000;
  localparam longint FLASH_UNIT_US     = 100000;
  localparam longint PAUSE_UNIT_US     = 1000000;
  localparam logic [31:0] BREAK_CYC      = 32'(BREAK_US * CLK_PER_US);
  localparam logic [31:0] MAKE_CYC       = 32'(MAKE_US * CLK_PER_US);
  localparam logic [31:0] IDP_UNIT_CYC   = 32'(INTERDIGIT_UNIT_US * CLK_PER_US);
  localparam logic [31:0] TONE_LONG_CYC  = 32'(TONE_LONG_US * CLK_PER_US);
  localparam logic [31:0] TONE_SHORT_CYC = 32'(TONE_SHORT_US * CLK_PER_US);
  localparam logic [31:0] FLASH_UNIT_CYC = 32'(FLASH_UNIT_US * CLK_PER_US);
  localparam logic [31:0] PAUSE_UNIT_CYC = 32'(PAUSE_UNIT_US * CLK_PER_US);

  // -------------------------------------------------------------------------
  // phase steps of a 24-bit accumulator at 40 MHz for rows 1-4 and columns 1-4
  // -------------------------------------------------------------------------
  localparam logic [23:0] STEP_ROW1 = 24'h000126;
  localparam logic [23:0] STEP_ROW2 = 24'h000144;
  localparam logic [23:0] STEP_ROW3 = 24'h000168;
  localparam logic [23:0] STEP_ROW4 = 24'h000188;
  localparam logic [23:0] STEP_COL1 = 24'h0001FE;
  localparam logic [23:0] STEP_COL2 = 24'h00022F;
  localparam logic [23:0] STEP_COL3 = 24'h000269;
  localparam logic [23:0] STEP_COL4 = 24'h0002B2;

endpackage

// ==== hdl/dialer.sv ====
/*
  telephone dialer: loop-disconnect pulse dialling, dtmf tone generation, flash and
  pause cycles, hardware mute and hook outputs, and a maskable completion request.
  assumes an APB master on the system clock and a line interface that reads the
  active-low mute and dial pulse pins and a digital tone level into a dac.
*/
// Added by the designer: register access over APB.
`timescale 1ns/100ps

// Behaviour
// - dial code write starts pulses or tone
// - pulse count equals code, ten for 1010B
// - code maps to keypad row and column
// - single tone or summed dual tone
// - receive mute low in pulse, flash cycles
// - transmit mute low in pulse, flash, tone, hold
// - hook bit drives dial pulse high
// - continuous tone until cleared, minimum kept
// - otherwise tone lasts minimum duration
// - mask gates completion request
// - flag set when dial, pause, flash complete
// - write one clears flag, zero ignored
// - no new function while flag set
// - request stays while flag and mask set
// - pause, flash triggers write-only, zero cancels
// - row, column enables select tone output
// - duration bit selects 47 or 94 ms
// - interdigit pause after each pulse digit
module dialer #(
  parameter logic [31:0] BREAK_CYC      = dialer_pkg::BREAK_CYC,      // dial pulse break time
  parameter logic [31:0] MAKE_CYC       = dialer_pkg::MAKE_CYC,       // dial pulse make time
  parameter logic [31:0] IDP_UNIT_CYC   = dialer_pkg::IDP_UNIT_CYC,   // interdigit step
  parameter logic [31:0] TONE_LONG_CYC  = dialer_pkg::TONE_LONG_CYC,  // 94 ms minimum tone
  parameter logic [31:0] TONE_SHORT_CYC = dialer_pkg::TONE_SHORT_CYC, // 47 ms minimum tone
  parameter logic [31:0] FLASH_UNIT_CYC = dialer_pkg::FLASH_UNIT_CYC, // flash step
  parameter logic [31:0] PAUSE_UNIT_CYC = dialer_pkg::PAUSE_UNIT_CYC  // pause step
) (
  input  wire logic        clock,                 // 40 MHz system clock
  input  wire logic        rst,                   // asynchronous reset, active high
  input  wire logic        ce,                    // clock enable, freezes all state when low
  input  wire logic        psel,                  // apb select
  input  wire logic        penable,               // apb access phase
  input  wire logic        pwrite,                // apb direction
  input  wire logic [17:0] paddr,                 // apb byte address
  input  wire logic [31:0] pwdata,                // apb write data
  output logic      [31:0] prdata,                // apb read data
  output logic             pready,                // apb ready
  output logic             pslverr,               // apb error on unmapped address
  input  wire logic        high_freq_oscillator,  // tone clock source running
  output logic             dial_pulse_out,        // line loop, high is off-hook
  output logic             receive_mute_out_n,    // receive mute, low mutes
  output logic             transmit_mute_out_n,   // transmit mute, low mutes
  output logic      [7:0]  tone_out,              // tone level to the dac
  output logic             dialing_irq            // completion request to the cpu
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    dialer_pkg::dial_state_t st;
    logic [31:0] cnt;       // cycles within the current step
    logic [3:0]  units;     // steps left in a multi-step wait
    logic [3:0]  pulses;    // dial pulses left
    logic [3:0]  dial_code;
    logic [3:0]  interdigit_pause_select;
    logic [3:0]  flash_time_select;
    logic [3:0]  pause_time_select;
    logic        continuous_tone_select;
    logic        tone_duration_select;
    logic        row_tone_enable;
    logic        column_tone_enable;
    logic        receive_mute_control;
    logic        transmit_mute_control;
    logic        hook_switch_control;
    logic        hold_line;
    logic        tone_mode;
    logic        dialing_interrupt_mask;
    logic        dialing_interrupt_flag;
    logic        min_done;  // minimum tone duration has elapsed
    logic [31:0] rdata;
    logic        rd_ok;     // read data captured for the address on the bus
    logic [23:0] row_phase;
    logic [23:0] col_phase;
    logic [7:0]  tone;
    logic        dp;
    logic        rx_n;
    logic        tx_n;
  } dialer_state_t;

  dialer_state_t s;
  dialer_state_t next_s;

  // -------------------------------------------------------------------------
  // keypad lookup: code to row and column index (0 = first)
  // -------------------------------------------------------------------------
  function automatic logic [3:0] keypad(input logic [3:0] code);
    logic [3:0] rc;
    rc = 4'h0;
    case (code)                              // {row, column}
      4'h1: rc = 4'h0;
      4'h2: rc = 4'h1;
      4'h3: rc = 4'h2;
      4'h4: rc = 4'h4;
      4'h5: rc = 4'h5;
      4'h6: rc = 4'h6;
      4'h7: rc = 4'h8;
      4'h8: rc = 4'h9;
      4'h9: rc = 4'hA;
      4'hA: rc = 4'hD;
      4'hB: rc = 4'hE;
      4'hC: rc = 4'hC;
      4'h0: rc = 4'h3;
      4'hD: rc = 4'h7;
      4'hF: rc = 4'hB;
      4'hE: rc = 4'hF;
      default: rc = 4'h0;
    endcase
    return rc;
  endfunction

  function automatic logic [23:0] row_step(input logic [1:0] r);
    logic [23:0] v;
    v = dialer_pkg::STEP_ROW1;
    case (r)
      2'h0: v = dialer_pkg::STEP_ROW1;
      2'h1: v = dialer_pkg::STEP_ROW2;
      2'h2: v = dialer_pkg::STEP_ROW3;
      default: v = dialer_pkg::STEP_ROW4;
    endcase
    return v;
  endfunction

  function automatic logic [23:0] col_step(input logic [1:0] c);
    logic [23:0] v;
    v = dialer_pkg::STEP_COL1;
    case (c)
      2'h0: v = dialer_pkg::STEP_COL1;
      2'h1: v = dialer_pkg::STEP_COL2;
      2'h2: v = dialer_pkg::STEP_COL3;
      default: v = dialer_pkg::STEP_COL4;
    endcase
    return v;
  endfunction

  // triangle wave from the phase: 0..127
  function automatic logic [6:0] tri_wave(input logic [23:0] ph);
    return ph[23] ? ~ph[22:16] : ph[22:16];
  endfunction

  // -------------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------------
  logic        hit;
  logic        wr_en;
  logic [15:0] idx;
  logic [3:0]  rc;
  logic [7:0]  tri_row;
  logic [7:0]  tri_col;
  logic [31:0] tone_min;

  assign idx = paddr[17:2];
  assign rc  = keypad(s.dial_code);
  assign tri_row = {1'b0, tri_wave(s.row_phase)};
  assign tri_col = {1'b0, tri_wave(s.col_phase)};
  assign tone_min = s.tone_duration_select ? TONE_SHORT_CYC : TONE_LONG_CYC;

  // address map check; low two address bits must be zero
  always_comb begin
    case (idx)
      dialer_pkg::IDX_CALL_CTRL, dialer_pkg::IDX_INTERDIGIT, dialer_pkg::IDX_TONE_CTRL,
      dialer_pkg::IDX_DIAL_CODE, dialer_pkg::IDX_LINE_CTRL, dialer_pkg::IDX_MODE,
      dialer_pkg::IDX_FLASH_TIME, dialer_pkg::IDX_PAUSE_TIME, dialer_pkg::IDX_IRQ_MASK,
      dialer_pkg::IDX_IRQ_FLAG: hit = (paddr[1:0] == 2'h0);
      default: hit = 1'b0;
    endcase
  end

  // writes need no wait; reads wait until data was captured in the setup cycle
  assign pready  = ce & (pwrite | s.rd_ok);
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & pready & hit;
  assign prdata  = s.rdata;

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    logic        idle_ok;
    logic        done;
    logic [31:0] rd;
    next_s   = s;
    idle_ok  = (s.st == dialer_pkg::ST_IDLE) & ~s.dialing_interrupt_flag;
    done     = 1'b0;
    rd       = 32'h0;
    next_s.cnt = s.cnt + 32'h1;

    // read mux; trigger bits always read zero
    case (idx)
      dialer_pkg::IDX_CALL_CTRL:  rd[dialer_pkg::BIT_HOLD] = s.hold_line;
      dialer_pkg::IDX_INTERDIGIT: rd[3:0] = s.interdigit_pause_select;
      dialer_pkg::IDX_TONE_CTRL:  rd[3:0] = {s.continuous_tone_select, s.tone_duration_select,
                                             s.row_tone_enable, s.column_tone_enable};
      dialer_pkg::IDX_DIAL_CODE:  rd[3:0] = s.dial_code;
      dialer_pkg::IDX_LINE_CTRL:  rd[2:0] = {s.hook_switch_control, s.receive_mute_control,
                                             s.transmit_mute_control};
      dialer_pkg::IDX_MODE:       rd[0]   = s.tone_mode;
      dialer_pkg::IDX_FLASH_TIME: rd[3:0] = s.flash_time_select;
      dialer_pkg::IDX_PAUSE_TIME: rd[3:0] = s.pause_time_select;
      dialer_pkg::IDX_IRQ_MASK:   rd[0]   = s.dialing_interrupt_mask;
      dialer_pkg::IDX_IRQ_FLAG:   rd[0]   = s.dialing_interrupt_flag;
      default:                    rd      = 32'h0;
    endcase
    next_s.rdata = psel ? (hit ? rd : 32'h0) : s.rdata; // misaligned or unmapped reads zero
    next_s.rd_ok = psel & ~(penable & pready);

    // sequencer: timed steps of pulse, tone, flash and pause cycles
    case (s.st)
      dialer_pkg::ST_BREAK: begin
        if (s.cnt >= BREAK_CYC - 32'h1) begin
          next_s.st  = dialer_pkg::ST_MAKE;
          next_s.cnt = 32'h0;
        end
      end
      dialer_pkg::ST_MAKE: begin
        if (s.cnt >= MAKE_CYC - 32'h1) begin
          next_s.cnt    = 32'h0;
          next_s.pulses = s.pulses - 4'h1;
          if (s.pulses == 4'h1) begin          // last pulse of the digit
            next_s.st    = dialer_pkg::ST_INTERDIGIT;
            next_s.units = s.interdigit_pause_select;
          end else begin
            next_s.st = dialer_pkg::ST_BREAK;
          end
        end
      end
      dialer_pkg::ST_INTERDIGIT, dialer_pkg::ST_FLASH, dialer_pkg::ST_PAUSE: begin
        // multi-step wait; a zero select ends after one step
        if ((s.st == dialer_pkg::ST_INTERDIGIT && s.cnt >= IDP_UNIT_CYC - 32'h1) ||
            (s.st == dialer_pkg::ST_FLASH && s.cnt >= FLASH_UNIT_CYC - 32'h1) ||
            (s.st == dialer_pkg::ST_PAUSE && s.cnt >= PAUSE_UNIT_CYC - 32'h1)) begin
          next_s.cnt   = 32'h0;
          next_s.units = s.units - 4'h1;
          if (s.units <= 4'h1) begin
            done      = 1'b1;
            next_s.st = dialer_pkg::ST_IDLE;
          end
        end
      end
      dialer_pkg::ST_TONE: begin
        if (s.cnt >= tone_min - 32'h1) begin
          next_s.min_done = 1'b1;
          next_s.cnt      = s.cnt;              // hold once the minimum is reached
        end
        // end at the minimum, or later once continuous output is cleared
        if ((s.min_done | (s.cnt >= tone_min - 32'h1)) & ~s.continuous_tone_select) begin
          done      = 1'b1;
          next_s.st = dialer_pkg::ST_IDLE;
        end
      end
      default: begin
        next_s.st  = dialer_pkg::ST_IDLE;
        next_s.cnt = 32'h0;
      end
    endcase

    // register writes and the functions they start
    if (wr_en) begin
      case (idx)
        dialer_pkg::IDX_CALL_CTRL: begin
          next_s.hold_line = pwdata[dialer_pkg::BIT_HOLD];
          if (pwdata[dialer_pkg::BIT_FLASH] & idle_ok) begin
            next_s.st    = dialer_pkg::ST_FLASH;
            next_s.cnt   = 32'h0;
            next_s.units = s.flash_time_select;
          end else if (pwdata[dialer_pkg::BIT_PAUSE] & idle_ok) begin
            next_s.st    = dialer_pkg::ST_PAUSE;
            next_s.cnt   = 32'h0;
            next_s.units = s.pause_time_select;
          end
          // a zero in a trigger bit cancels that function, no completion flag
          if ((~pwdata[dialer_pkg::BIT_FLASH] & (s.st == dialer_pkg::ST_FLASH)) |
              (~pwdata[dialer_pkg::BIT_PAUSE] & (s.st == dialer_pkg::ST_PAUSE))) begin
            next_s.st = dialer_pkg::ST_IDLE;
            done      = 1'b0;
          end
        end
        dialer_pkg::IDX_INTERDIGIT: next_s.interdigit_pause_select = pwdata[3:0];
        dialer_pkg::IDX_TONE_CTRL: begin
          next_s.continuous_tone_select = pwdata[dialer_pkg::BIT_CONTIN];
          next_s.tone_duration_select   = pwdata[dialer_pkg::BIT_DURATION];
          next_s.row_tone_enable        = pwdata[dialer_pkg::BIT_ROW];
          next_s.column_tone_enable     = pwdata[dialer_pkg::BIT_COLUMN];
        end
        dialer_pkg::IDX_DIAL_CODE: begin
          next_s.dial_code = pwdata[3:0];
          if (idle_ok) begin
            next_s.cnt = 32'h0;
            if (s.tone_mode) begin
              next_s.st       = dialer_pkg::ST_TONE;
              next_s.min_done = 1'b0;
            end else if (pwdata[3:0] == 4'h0) begin
              // unsupported code: no pulses, only the interdigit gap
              next_s.st    = dialer_pkg::ST_INTERDIGIT;
              next_s.units = s.interdigit_pause_select;
            end else begin
              next_s.st     = dialer_pkg::ST_BREAK;
              next_s.pulses = pwdata[3:0];
            end
          end
        end
        dialer_pkg::IDX_LINE_CTRL: begin
          next_s.hook_switch_control   = pwdata[dialer_pkg::BIT_HOOK];
          next_s.receive_mute_control  = pwdata[dialer_pkg::BIT_RX_MUTE];
          next_s.transmit_mute_control = pwdata[dialer_pkg::BIT_TX_MUTE];
        end
        dialer_pkg::IDX_MODE:       next_s.tone_mode         = pwdata[0];
        dialer_pkg::IDX_FLASH_TIME: next_s.flash_time_select = pwdata[3:0];
        dialer_pkg::IDX_PAUSE_TIME: next_s.pause_time_select = pwdata[3:0];
        dialer_pkg::IDX_IRQ_MASK:   next_s.dialing_interrupt_mask = pwdata[0];
        dialer_pkg::IDX_IRQ_FLAG: begin
          if (pwdata[0])
            next_s.dialing_interrupt_flag = 1'b0;
        end
        default: next_s.hold_line = s.hold_line;
      endcase
    end

    // completion sets the flag; placed last so a set beats a same-cycle clear
    if (done)
      next_s.dialing_interrupt_flag = 1'b1;

    // tone generator runs only while a tone cycle is active and the oscillator runs
    if (next_s.st == dialer_pkg::ST_TONE && high_freq_oscillator) begin
      next_s.row_phase = s.row_phase + row_step(rc[3:2]);
      next_s.col_phase = s.col_phase + col_step(rc[1:0]);
    end else if (next_s.st != dialer_pkg::ST_TONE) begin
      next_s.row_phase = 24'h0;
      next_s.col_phase = 24'h0;
    end

    // tone level: dc, column, row or the sum of both
    if (next_s.st != dialer_pkg::ST_TONE) begin
      next_s.tone = dialer_pkg::TONE_MID_LEVEL;
    end else begin
      case ({s.row_tone_enable, s.column_tone_enable})
        2'b01:   next_s.tone = {tri_col[6:0], 1'b0};
        2'b10:   next_s.tone = {tri_row[6:0], 1'b0};
        2'b11:   next_s.tone = tri_row + tri_col;
        default: next_s.tone = dialer_pkg::TONE_MID_LEVEL;
      endcase
    end

    // line pins: loop opens during break and flash; off-hook otherwise follows the hook bit
    next_s.dp = next_s.hook_switch_control &
                ~((next_s.st == dialer_pkg::ST_BREAK) | (next_s.st == dialer_pkg::ST_FLASH));
    // receive mute during the whole pulse digit and flash
    next_s.rx_n = next_s.receive_mute_control &
                  ~((next_s.st == dialer_pkg::ST_BREAK) | (next_s.st == dialer_pkg::ST_MAKE) |
                    (next_s.st == dialer_pkg::ST_INTERDIGIT) | (next_s.st == dialer_pkg::ST_FLASH));
    // transmit mute also covers tone and hold-line
    next_s.tx_n = next_s.transmit_mute_control &
                  ~((next_s.st == dialer_pkg::ST_BREAK) | (next_s.st == dialer_pkg::ST_MAKE) |
                    (next_s.st == dialer_pkg::ST_INTERDIGIT) | (next_s.st == dialer_pkg::ST_FLASH) |
                    (next_s.st == dialer_pkg::ST_TONE) | next_s.hold_line);
  end

  // -------------------------------------------------------------------------
  // state register; ce low freezes everything
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s                          <= '0;
      s.st                       <= dialer_pkg::ST_IDLE;
      s.dial_code                <= dialer_pkg::RST_DIAL_CODE;
      s.interdigit_pause_select  <= dialer_pkg::RST_INTERDIGIT;
      s.flash_time_select        <= dialer_pkg::RST_FLASH_TIME;
      s.pause_time_select        <= dialer_pkg::RST_PAUSE_TIME;
      s.row_tone_enable          <= 1'b1;
      s.column_tone_enable       <= 1'b1;
      s.receive_mute_control     <= 1'b1;
      s.transmit_mute_control    <= 1'b1;
      s.tone                     <= dialer_pkg::TONE_MID_LEVEL;
      s.rx_n                     <= 1'b1;
      s.tx_n                     <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // -------------------------------------------------------------------------
  // outputs; the request stays up while flag and mask are both set
  // -------------------------------------------------------------------------
  assign dial_pulse_out      = s.dp;
  assign receive_mute_out_n  = s.rx_n;
  assign transmit_mute_out_n = s.tx_n;
  assign tone_out            = s.tone;
  assign dialing_irq         = s.dialing_interrupt_flag & s.dialing_interrupt_mask;

endmodule

// ==== tb/line_model.sv ====
/* line side model: counts loop breaks on the dial pulse pin.
   assumes hook is closed so each fall is one break. */
`timescale 1ns/100ps
module line_model (
  input  wire logic clock,          // system clock
  input  wire logic rst,            // reset, active high
  input  wire logic dial_pulse_out, // loop state, high closed
  output int        breaks          // breaks seen so far
);
  logic last;
  // the exchange counts every open of the loop as one digit step
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last   <= 1'b0;
      breaks <= 0;
    end else begin
      last <= dial_pulse_out;
      if (last && !dial_pulse_out) breaks <= breaks + 1;
    end
  end
endmodule

// ==== tb/dialer_asserts.sv ====
/* checker of dialer port relations.
   assumes one clock domain, bound to dialer. */
`timescale 1ns/100ps
module dialer_asserts (
  input wire logic        clock, rst, ce, psel, penable, pwrite, pready, pslverr,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        receive_mute_out_n, transmit_mute_out_n, dialing_irq,
  input wire logic [7:0]  tone_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire acc = psel && penable && ce;
  chk_flag_clear: assert property (acc && pwrite && paddr == 18'h3FFE4 && pwdata[0] |=> !dialing_irq)
    else $error("irq after flag clear");
  chk_mask_off: assert property (acc && pwrite && paddr == 18'h3FFA4 && !pwdata[0] |=> !dialing_irq)
    else $error("irq with mask off");
  chk_irq_stays: assert property (dialing_irq && !(acc && pwrite) |=> dialing_irq)
    else $error("irq dropped by itself");
  chk_rx_tx_mute: assert property (!receive_mute_out_n |-> !transmit_mute_out_n)
    else $error("rx mute without tx mute");
  chk_tone_mute: assert property (tone_out != 8'h80 |-> !transmit_mute_out_n)
    else $error("tone without tx mute");
  chk_trig_zero: assert property (acc && !pwrite && pready && paddr == 18'h3FC50 |-> prdata[1:0] == 2'h0)
    else $error("trigger bits read back");
  chk_err_zero: assert property (acc && !pwrite && pready && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_write_ready: assert property (acc && pwrite |-> pready)
    else $error("write held off");
endmodule
bind dialer dialer_asserts i_dialer_asserts (.*);

// ==== tb/telephone_dialer_control_tb_top.sv ====
/* self-checking bench of the dialer over apb.
   assumes shortened counts set below; flash keeps its full count and is only cut. */
`timescale 1ns/100ps
module telephone_dialer_control_tb_top;
  logic clock = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, osc = 0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, dp, rx_n, tx_n, irq, qe;
  logic [7:0]  tone;
  int          errors = 0, samples_checked = 0, cyc = 0, n, b, b0;
  always #12.5 clock = ~clock;
  dialer #(.BREAK_CYC(32'h4), .MAKE_CYC(32'h3), .IDP_UNIT_CYC(32'h5), .TONE_LONG_CYC(32'h14),
    .TONE_SHORT_CYC(32'hA)) i_dialer (.clock(clock),
    .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .high_freq_oscillator(osc), .dial_pulse_out(dp),
    .receive_mute_out_n(rx_n), .transmit_mute_out_n(tx_n), .tone_out(tone), .dialing_irq(irq));
  line_model i_line_model (.clock(clock), .rst(rst), .dial_pulse_out(dp), .breaks(b));
  task results;
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // one apb transfer; ends one idle edge after release
  task apb(input logic [15:0] i, input logic w, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= d;
    @(posedge clock) penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata; qe = pslverr; psel <= 0; penable <= 0;
    @(posedge clock);
  endtask
  task rd(input string s, input logic [15:0] i, input logic [31:0] e);
    apb(i, 0, 32'h0); chk(s, q, e);
  endtask
  task wait_irq;
    n = 0;
    while (irq !== 1'b1) begin @(posedge clock); n++; end
  endtask
  // hang guard, well above the run length
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin errors++; results; end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    rd("tone_ctrl", dialer_pkg::IDX_TONE_CTRL, 32'h3);
    rd("dial_code", dialer_pkg::IDX_DIAL_CODE, 32'h0);
    rd("line_ctrl", dialer_pkg::IDX_LINE_CTRL, 32'h3);
    rd("mask", dialer_pkg::IDX_IRQ_MASK, 32'h0);
    rd("call_ctrl", dialer_pkg::IDX_CALL_CTRL, 32'h0);
    apb(dialer_pkg::IDX_LINE_CTRL, 1, 32'h7);
    @(posedge clock) chk("hook", dp, 32'h1);
    apb(dialer_pkg::IDX_IRQ_MASK, 1, 32'h1);
    b0 = b; apb(dialer_pkg::IDX_DIAL_CODE, 1, 32'hA); ce <= 0; // digit zero, never code 0
    repeat (100) @(posedge clock);
    chk("frozen", b - b0, 32'h1);
    chk("rx_mute", rx_n, 32'h0); chk("tx_mute", tx_n, 32'h0);
    ce <= 1; wait_irq;
    chk("pulses", b - b0, 32'hA); chk("gap", n >= 105, 32'h1);
    apb(dialer_pkg::IDX_DIAL_CODE, 1, 32'h3); repeat (60) @(posedge clock);
    chk("refused", b - b0, 32'hA);
    apb(dialer_pkg::IDX_IRQ_FLAG, 1, 32'h0); rd("flag_kept", dialer_pkg::IDX_IRQ_FLAG, 32'h1);
    apb(dialer_pkg::IDX_IRQ_FLAG, 1, 32'h1); rd("flag_clr", dialer_pkg::IDX_IRQ_FLAG, 32'h0);
    osc <= 1; apb(dialer_pkg::IDX_MODE, 1, 32'h1); // oscillator first
    apb(dialer_pkg::IDX_DIAL_CODE, 1, 32'h5); chk("tone_on", tone != 8'h80, 32'h1);
    chk("tone_tx", tx_n, 32'h0); chk("tone_rx", rx_n, 32'h1); wait_irq;
    chk("tone_long", n >= 16 && n <= 23, 32'h1);
    apb(dialer_pkg::IDX_IRQ_FLAG, 1, 32'h1); apb(dialer_pkg::IDX_TONE_CTRL, 1, 32'h7);
    apb(dialer_pkg::IDX_DIAL_CODE, 1, 32'h1); wait_irq;
    chk("tone_short", n >= 6 && n <= 13, 32'h1);
    apb(dialer_pkg::IDX_IRQ_FLAG, 1, 32'h1); apb(dialer_pkg::IDX_TONE_CTRL, 1, 32'h8);
    apb(dialer_pkg::IDX_DIAL_CODE, 1, 32'hD); repeat (40) @(posedge clock);
    chk("cont_on", irq, 32'h0);
    chk("dc_level", tone, 32'h80);
    apb(dialer_pkg::IDX_TONE_CTRL, 1, 32'h3); wait_irq;
    chk("cont_end", n <= 4, 32'h1);
    rd("unmapped", 16'h0100, 32'h0); chk("slverr", qe, 32'h1);
    apb(dialer_pkg::IDX_IRQ_MASK, 1, 32'h0);
    @(posedge clock) chk("masked", irq, 32'h0);
    apb(dialer_pkg::IDX_IRQ_FLAG, 1, 32'h1); apb(dialer_pkg::IDX_FLASH_TIME, 1, 32'h2); // never zero
    apb(dialer_pkg::IDX_CALL_CTRL, 1, 32'h1); chk("flash_dp", dp, 32'h0);
    chk("flash_rx", rx_n, 32'h0);
    apb(dialer_pkg::IDX_CALL_CTRL, 1, 32'h0); chk("flash_cut", dp, 32'h1);
    rd("no_flag", dialer_pkg::IDX_IRQ_FLAG, 32'h0);
    results;
  end
endmodule
